// ===== pkg/uart_pkg.sv
// Purpose: shared constants and types of the serial transceiver core
// Assumes: word-indexed register port, one system clock
// Notes: register index equals the printed offset
package uart_pkg;
	// clock and default line rate
	localparam int CLK_HZ = 10_000_000;
	localparam int BAUD_BPS = 115200;
	localparam logic [15:0] DIV_RESET =
		16'((CLK_HZ + BAUD_BPS / 2) / BAUD_BPS);
	localparam int SIM_BIT_CYCLES = 2;
	// register indices
	localparam logic [2:0] OFS_RXDATA = 3'h0;
	localparam logic [2:0] OFS_TXDATA = 3'h1;
	localparam logic [2:0] OFS_STATUS = 3'h2;
	localparam logic [2:0] OFS_CONTROL = 3'h3;
	localparam logic [2:0] OFS_DIVISOR = 3'h4;
	localparam logic [2:0] OFS_PKTEND = 3'h5;
	// status bit positions
	localparam int ST_PARERR = 0;
	localparam int ST_FE = 1;
	localparam int ST_BRK = 2;
	localparam int ST_ROE = 3;
	localparam int ST_TOE = 4;
	localparam int ST_TMT = 5;
	localparam int ST_TRDY = 6;
	localparam int ST_RRDY = 7;
	localparam int ST_CTSCHG = 10;
	localparam int ST_CTS = 11;
	localparam int ST_EOP = 12;
	// control bit positions
	localparam int CT_CTSCHG_IE = 10;
	localparam int CT_RTS = 11;
	localparam int CT_IEOP = 12;
	// reset values
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [8:0] PKTEND_RESET = 9'h000;
	localparam logic [15:0] RDATA_RESET = 16'h0000;
	// modes and states
	typedef enum logic [1:0] {PAR_NONE, PAR_ODD, PAR_EVEN} parity_t;
	typedef enum logic [2:0] {
		RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
	} rx_state_t;
	// register port carriers
	typedef struct packed {
		logic sel;
		logic rd;
		logic wr;
		logic [2:0] addr;
		logic [15:0] wdata;
	} bus_req_t;
	typedef struct packed {
		logic ack;
		logic eop;
		logic rdy;
		logic avail;
		logic [15:0] rdata;
	} bus_rsp_t;
endpackage

// ===== design/uart_core.sv
// Purpose: serial transceiver with parity, line status pins, packet end
// Assumes: request held until ack; rxd, ctsN asynchronous to core_clk
// Notes: SIM_ACCEL is for simulation builds only, keep 0 in silicon
module uart_core import uart_pkg::*; #(
	parameter int DATA_BITS = 8,
	parameter int STOP_BITS = 1,
	parameter parity_t PARITY = PAR_NONE,
	parameter bit FLOW_CTRL = 1'b1,
	parameter bit HANDSHAKE = 1'b1,
	parameter bit USE_EOP = 1'b1,
	parameter bit SIM_ACCEL = 1'b0
) (
	input wire logic core_clk, // system clock
	input wire logic reset_n, // async reset, active low
	input wire bus_req_t busReq, // register request
	output bus_rsp_t busRsp, // register answer
	input wire logic rxd, // serial input
	output logic txd, // serial output
	input wire logic ctsN, // clear to send, active low
	output logic rtsN // request to send, active low
);
	localparam int DW = DATA_BITS;
	localparam int PB = (PARITY == PAR_NONE) ? 0 : 1;
	localparam int FL = 1 + DW + PB + STOP_BITS;
	localparam logic [3:0] FL4 = 4'(FL);
	localparam logic [3:0] LASTBIT = 4'(DW - 1);

	// configuration check
	if (DATA_BITS < 7 || DATA_BITS > 9 || STOP_BITS < 1 ||
		STOP_BITS > 2) begin : badCfg
		$error("uart_core: unsupported character format");
	end

	// parity of a character
	function automatic logic parBit(input logic [DW-1:0] d);
		parBit = (PARITY == PAR_EVEN) ? ~^d : ^d;
	endfunction

	logic [1:0] rxS_r, ctsS_r;
	logic rxPrev_r, ctsPrev_r;
	logic [FL-1:0] txSh_r;
	logic [3:0] txBits_r, rxIdx_r;
	logic [15:0] txCnt_r, rxCnt_r, divisor_r, ctrl_r;
	logic [DW-1:0] txHold_r, rxSh_r, rxData_r, pktEnd_r;
	logic txFull_r, rrdy_r, parErr_r, fe_r, brk_r, roe_r, toe_r;
	logic ctsChgFlag_r, eop_r, rxPar_r, rtsN_r;
	rx_state_t rxState_r;
	bus_rsp_t busRsp_r;

	// two-flop synchronisers for pins
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rxS_r <= 2'h3;
			ctsS_r <= 2'h3;
			rxPrev_r <= 1'b1;
			ctsPrev_r <= 1'b1;
		end else begin
			rxS_r <= {rxS_r[0], rxd};
			ctsS_r <= {ctsS_r[0], ctsN};
			rxPrev_r <= rxS_r[1];
			ctsPrev_r <= ctsS_r[1];
		end
	end

	wire rxBit = rxS_r[1];
	wire ctsBit = FLOW_CTRL & ~ctsS_r[1];
	wire ctsChg = FLOW_CTRL & (ctsS_r[1] != ctsPrev_r);

	// request decode and handshake stall
	wire [2:0] adr = busReq.addr;
	wire req = busReq.sel & (busReq.rd | busReq.wr) & ~busRsp_r.ack;
	wire wantTx = busReq.wr & (adr == OFS_TXDATA);
	wire wantRx = busReq.rd & (adr == OFS_RXDATA);
	wire stall = HANDSHAKE & ((wantTx & txFull_r) | (wantRx & ~rrdy_r));
	wire act = req & ~stall;
	wire wr = act & busReq.wr;
	wire rd = act & busReq.rd;
	wire txWr = wr & (adr == OFS_TXDATA);
	wire rxRd = rd & (adr == OFS_RXDATA);
	wire stWr = wr & (adr == OFS_STATUS);
	wire ctWr = wr & (adr == OFS_CONTROL);
	wire dvWr = wr & (adr == OFS_DIVISOR);
	wire pktEndWr = wr & (adr == OFS_PKTEND) & USE_EOP;
	wire [DW-1:0] wChar = busReq.wdata[DW-1:0];
	wire eopHit = USE_EOP & ((txWr & (wChar == pktEnd_r)) |
		(rxRd & (rxData_r == pktEnd_r)));

	// transmitter timing and frame
	wire [15:0] divEff = SIM_ACCEL ? 16'(SIM_BIT_CYCLES - 1) : divisor_r;
	wire txShift = (txBits_r != 4'h0) & (txCnt_r == 16'h0000);
	wire txLoad = (txBits_r == 4'h0) & txFull_r;
	wire [FL-1:0] txFrame;
	if (PB != 0) begin : withPar
		assign txFrame = {{STOP_BITS{1'b1}}, parBit(txHold_r),
			txHold_r, 1'b0};
	end else begin : noPar
		assign txFrame = {{STOP_BITS{1'b1}}, txHold_r, 1'b0};
	end

	// transmit shifter, lsb after start bit
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			txSh_r <= '1;
			txBits_r <= 4'h0;
			txCnt_r <= 16'h0000;
		end else if (txLoad) begin
			txSh_r <= txFrame;
			txBits_r <= FL4;
			txCnt_r <= divEff;
		end else if (txShift) begin
			txSh_r <= {1'b1, txSh_r[FL-1:1]};
			txBits_r <= txBits_r - 4'h1;
			txCnt_r <= divEff;
		end else if (txBits_r != 4'h0) begin
			txCnt_r <= txCnt_r - 16'h0001;
		end
	end

	// holding register and transmit flags
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			txHold_r <= '0;
			txFull_r <= 1'b0;
		end else begin
			if (txWr & (~txFull_r | txLoad))
				txHold_r <= wChar;
			txFull_r <= txWr | (txFull_r & ~txLoad);
		end
	end

	// receiver sequence
	wire rxTick = (rxCnt_r == 16'h0000);
	wire rxDone = (rxState_r == RX_STOP) & rxTick;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rxState_r <= RX_IDLE;
			rxCnt_r <= 16'h0000;
			rxIdx_r <= 4'h0;
			rxSh_r <= '0;
			rxPar_r <= 1'b0;
		end else begin
			rxCnt_r <= rxTick ? divisor_r : rxCnt_r - 16'h0001;
			case (rxState_r)
				RX_IDLE: begin
					rxCnt_r <= divisor_r >> 1;
					if (rxPrev_r & ~rxBit)
						rxState_r <= RX_START;
				end
				RX_START: begin
					rxIdx_r <= 4'h0;
					if (rxTick)
						rxState_r <= rxBit ? RX_IDLE : RX_DATA;
				end
				RX_DATA: begin
					if (rxTick) begin
						rxSh_r <= {rxBit, rxSh_r[DW-1:1]};
						rxIdx_r <= rxIdx_r + 4'h1;
						if (rxIdx_r == LASTBIT)
							rxState_r <= (PB != 0) ? RX_PAR : RX_STOP;
					end
				end
				RX_PAR: begin
					if (rxTick) begin
						rxPar_r <= rxBit;
						rxState_r <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (rxTick)
						rxState_r <= RX_IDLE;
				end
				default: rxState_r <= RX_IDLE;
			endcase
		end
	end

	// sticky status flags, set wins over clear
	wire parErrSet = rxDone & (PB != 0) & (rxPar_r != parBit(rxSh_r));
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rxData_r <= '0;
			{rrdy_r, parErr_r, fe_r, brk_r, roe_r, toe_r} <= 6'h00;
			{ctsChgFlag_r, eop_r} <= 2'h0;
		end else begin
			if (rxDone)
				rxData_r <= rxSh_r;
			rrdy_r <= rxDone | (rrdy_r & ~rxRd);
			parErr_r <= parErrSet | (parErr_r & ~stWr);
			fe_r <= (rxDone & ~rxBit) | (fe_r & ~stWr);
			brk_r <= (rxDone & ~rxBit & (rxSh_r == '0)) |
				(brk_r & ~stWr);
			roe_r <= (rxDone & rrdy_r & ~rxRd) | (roe_r & ~stWr);
			toe_r <= (txWr & txFull_r & ~txLoad) | (toe_r & ~stWr);
			ctsChgFlag_r <= ctsChg | (ctsChgFlag_r & ~stWr);
			eop_r <= (act & eopHit) | (eop_r & ~stWr);
		end
	end

	// control, divisor, packet-end registers
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_r <= CTRL_RESET;
			divisor_r <= DIV_RESET;
			pktEnd_r <= PKTEND_RESET[DW-1:0];
			rtsN_r <= 1'b1;
		end else begin
			if (ctWr)
				ctrl_r <= busReq.wdata;
			if (dvWr)
				divisor_r <= busReq.wdata;
			if (pktEndWr)
				pktEnd_r <= wChar;
			rtsN_r <= ~(FLOW_CTRL & ctrl_r[CT_RTS]);
		end
	end

	// status and control read images
	logic [15:0] statW, ctrlW, rdMux;
	always_comb begin
		statW = 16'h0000;
		statW[ST_PARERR] = parErr_r;
		statW[ST_FE] = fe_r;
		statW[ST_BRK] = brk_r;
		statW[ST_ROE] = roe_r;
		statW[ST_TOE] = toe_r;
		statW[ST_TMT] = (txBits_r == 4'h0) & ~txFull_r;
		statW[ST_TRDY] = ~txFull_r;
		statW[ST_RRDY] = rrdy_r;
		statW[ST_CTSCHG] = ctsChgFlag_r;
		statW[ST_CTS] = ctsBit;
		statW[ST_EOP] = USE_EOP & eop_r;
		ctrlW = ctrl_r;
		ctrlW[CT_CTSCHG_IE] = FLOW_CTRL & ctrl_r[CT_CTSCHG_IE];
		ctrlW[CT_RTS] = FLOW_CTRL & ctrl_r[CT_RTS];
		ctrlW[CT_IEOP] = USE_EOP & ctrl_r[CT_IEOP];
	end

	// read data select
	always_comb begin
		case (adr)
			OFS_RXDATA: rdMux = 16'(rxData_r);
			OFS_STATUS: rdMux = statW;
			OFS_CONTROL: rdMux = ctrlW;
			OFS_DIVISOR: rdMux = divisor_r;
			OFS_PKTEND: rdMux = USE_EOP ? 16'(pktEnd_r) : 16'h0000;
			default: rdMux = 16'h0000;
		endcase
	end

	// registered answer with flow signals
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			busRsp_r <= '{1'b0, 1'b0, 1'b1, 1'b0, RDATA_RESET};
		end else begin
			busRsp_r.ack <= act;
			busRsp_r.eop <= act & eopHit;
			busRsp_r.rdy <= ~(txWr | (txFull_r & ~txLoad));
			busRsp_r.avail <= rxDone | (rrdy_r & ~rxRd);
			busRsp_r.rdata <= rd ? rdMux : RDATA_RESET;
		end
	end

	assign busRsp = busRsp_r;
	assign txd = txSh_r[0];
	assign rtsN = rtsN_r;

	// checks
	sequence bitHold;
		!txShift ##1 txShift;
	endsequence
	no_parity_flag_a: assert property (@(posedge core_clk)
		disable iff (!reset_n) (PB == 0) |-> !statW[ST_PARERR])
		else $error("parity flag set without parity");
	flow_bits_off_a: assert property (@(posedge core_clk)
		disable iff (!reset_n) !FLOW_CTRL |-> (rtsN && !statW[ST_CTS]
		&& !statW[ST_CTSCHG] && !ctrlW[CT_CTSCHG_IE]))
		else $error("flow bits live while excluded");
	tx_parity_bit_a: assert property (@(posedge core_clk)
		disable iff (!reset_n) (PB != 0 && txLoad) |=>
		txSh_r[DW+1] == parBit($past(txHold_r)))
		else $error("wrong transmit parity bit");
	rx_parity_err_a: assert property (@(posedge core_clk)
		disable iff (!reset_n) parErrSet |=> parErr_r)
		else $error("parity error not flagged");
	cts_change_a: assert property (@(posedge core_clk)
		disable iff (!reset_n) ctsChg |=> statW[ST_CTSCHG])
		else $error("cts change not flagged");
	stall_write_a: assert property (@(posedge core_clk)
		disable iff (!reset_n) (HANDSHAKE && req && wantTx && txFull_r)
		|=> !busRsp_r.ack)
		else $error("write taken while full");
	sim_bit_time_a: assert property (@(posedge core_clk)
		disable iff (!reset_n) (SIM_ACCEL && txShift &&
		txBits_r > 4'h1) |=> bitHold)
		else $error("simulated bit time not two cycles");
	eop_match_a: assert property (@(posedge core_clk)
		disable iff (!reset_n) (act && eopHit) |=>
		(busRsp_r.ack && busRsp_r.eop && eop_r))
		else $error("packet end not signalled");
	lsb_first_a: assert property (@(posedge core_clk)
		disable iff (!reset_n) (txShift && txBits_r > 4'h1) |=>
		txd == $past(txSh_r[1]))
		else $error("transmit order broken");
	first_stop_a: assert property (@(posedge core_clk)
		disable iff (!reset_n) rxDone |=> rxState_r == RX_IDLE)
		else $error("receiver waited past first stop bit");
	pktend_off_a: assert property (@(posedge core_clk)
		disable iff (!reset_n) !USE_EOP |-> $stable(pktEnd_r))
		else $error("packet-end register written while excluded");
endmodule

// ===== verification/uart_remote.sv
// Purpose: remote serial device facing the core's line side
// Assumes: even parity, eight data bits, one stop bit, idle high
// Notes: sendChar may corrupt parity on request of the bench
module uart_remote #(
	parameter int BIT_NS = 8800
) (
	output logic rxd, // line into the core
	input wire logic txd // line out of the core
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [9:0] got [$]; // {stop, parity, data} of each frame seen
	logic [9:0] frame;
	initial rxd = 1'b1; // idle at mark level
	// sample each frame mid-bit, data least significant first
	always begin
		@(negedge txd);
		#(BIT_NS * 3 / 2);
		for (int i = 0; i < 10; i++) begin
			frame[i] = txd;
			if (i < 9) begin
				#(BIT_NS);
			end
		end
		got.push_back(frame);
	end
	// send one frame, even parity unless told to break it
	task automatic sendChar(input logic [7:0] d, input logic badPar);
		logic [10:0] f;
		f = {1'b1, (~^d) ^ badPar, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			rxd = f[i];
			#(BIT_NS);
		end
	endtask
endmodule

// ===== verification/uart_core_tb.sv
// Purpose: self-checking bench for the serial transceiver core
// Assumes: even parity, handshake, flow pins and packet end built in
// Notes: default divisor, so one bit lasts divisor+1 clocks
module uart_core_tb import uart_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BIT_NS = (int'(DIV_RESET) + 1) * 100;
	logic coreClk = 1'b0;
	logic resetN = 1'b0;
	logic ctsN = 1'b1;
	bus_req_t busReq = '0;
	bus_rsp_t busRsp;
	logic rxd, txd, rtsN, eopSeen;
	logic [15:0] rd;
	logic [7:0] c;
	logic [7:0] ch [4];
	int err_count = 0;
	int checks = 0;
	// clock, 100 ns period
	always #50 coreClk = ~coreClk;
	uart_core #(.PARITY(PAR_EVEN)) uut (.core_clk(coreClk),
		.reset_n(resetN), .busReq(busReq), .busRsp(busRsp), .rxd(rxd),
		.txd(txd), .ctsN(ctsN), .rtsN(rtsN));
	uart_remote #(.BIT_NS(BIT_NS)) remote (.rxd(rxd), .txd(txd));
	// expected parity bit, even mode
	function automatic logic evenBit(input logic [7:0] d);
		return ($countones(d) % 2) == 0;
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one register access, held until ack, dropped in the ack cycle
	task automatic busOp(input logic wr, input logic [2:0] addr,
		input logic [15:0] wdata);
		int n;
		n = 0;
		@(negedge coreClk);
		busReq = '{sel: 1'b1, rd: ~wr, wr: wr, addr: addr, wdata: wdata};
		do begin
			@(negedge coreClk);
			n++;
		end while (busRsp.ack !== 1'b1 && n < 30000);
		rd = busRsp.rdata;
		eopSeen = busRsp.eop;
		busReq = '0;
		check(16'(busRsp.ack), 16'h0001);
	endtask
	task automatic wrap_up();
		$display("counts: %0d checks, %0d mismatches", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// watchdog against a hung handshake
	initial begin
		#(3_000_000);
		err_count++;
		wrap_up();
	end
	// main sequence
	initial begin
		void'($urandom(32'h0436ae8e));
		repeat (5) @(posedge coreClk);
		@(negedge coreClk) resetN = 1'b1;
		check(16'({busRsp.rdy, busRsp.avail, txd, rtsN}), 16'h000b);
		busOp(1'b0, OFS_DIVISOR, 16'h0000);
		check(rd, 16'(DIV_RESET));
		busOp(1'b0, OFS_CONTROL, 16'h0000);
		check(rd, CTRL_RESET);
		busOp(1'b0, OFS_PKTEND, 16'h0000);
		check(rd, 16'(PKTEND_RESET));
		busOp(1'b0, 3'h6, 16'h0000);
		check(rd, 16'h0000);
		busOp(1'b1, OFS_PKTEND, 16'hffff);
		busOp(1'b0, OFS_PKTEND, 16'h0000);
		check(rd, 16'h00ff);
		busOp(1'b1, OFS_PKTEND, 16'h005a);
		$display("register test done");
		// back-to-back writes, later ones stall on a full transmitter
		ch[0] = 8'h00;
		ch[1] = 8'hff;
		ch[2] = 8'($urandom);
		ch[3] = 8'h5a;
		foreach (ch[i]) begin
			busOp(1'b1, OFS_TXDATA, {8'h00, ch[i]});
			check(16'(eopSeen), 16'(ch[i] == 8'h5a));
		end
		for (int n = 0; n < 60000 && remote.got.size() < 4; n++) begin
			@(posedge coreClk);
		end
		foreach (ch[i]) begin
			check(16'(remote.got[i]), {7'h01, evenBit(ch[i]), ch[i]});
		end
		busOp(1'b0, OFS_STATUS, 16'h0000);
		check(rd & 16'h1000, 16'h1000);
		busOp(1'b1, OFS_STATUS, 16'h0000);
		$display("transmit test done");
		// read waits for the frame; second frame has bad parity
		for (int i = 0; i < 2; i++) begin
			c = (i == 0) ? 8'h5a : 8'($urandom);
			fork
				remote.sendChar(c, i[0]);
				busOp(1'b0, OFS_RXDATA, 16'h0000);
			join
			check(rd, {8'h00, c});
			check(16'(eopSeen), 16'(c == 8'h5a));
			busOp(1'b0, OFS_STATUS, 16'h0000);
			check(rd & 16'h0001, 16'(i));
			busOp(1'b1, OFS_STATUS, 16'h0000);
		end
		$display("receive test done");
		// flow pins reach their register bits
		@(negedge coreClk) ctsN = 1'b0;
		repeat (4) @(negedge coreClk);
		busOp(1'b0, OFS_STATUS, 16'h0000);
		check(rd & 16'h0c00, 16'h0c00);
		busOp(1'b1, OFS_STATUS, 16'h0000);
		busOp(1'b0, OFS_STATUS, 16'h0000);
		check(rd & 16'h0c00, 16'h0800);
		busOp(1'b1, OFS_CONTROL, 16'h1c00);
		repeat (2) @(negedge coreClk);
		check(16'(rtsN), 16'h0000);
		busOp(1'b0, OFS_CONTROL, 16'h0000);
		check(rd, 16'h1c00);
		$display("flow pin test done");
		wrap_up();
	end
endmodule
